// [logic/ssi_encoder_reader.sv]
// one serial encoder reader channel with a classic wishbone register slave
`timescale 1ns/1ps
module ssi_encoder_reader
    import ssi_reader_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // system
    input  wire logic        clk,
    input  wire logic        rstn,
    // wishbone slave
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    // encoder link
    output logic             ssi_clk_out,
    output logic             ssi_clk_oe,
    input  wire logic        ssi_data_in,
    // completion event
    output logic             irq
);

    state_t cur;
    state_t next;
    logic   std_mode;
    logic   bus_req;
    logic   data_bit;

    // byte lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // half period of the serial clock in core cycles
    function automatic logic [15:0] half_cycles(input logic [1:0] rate);
        case (rate)
            2'h0:    return HALF0;
            2'h1:    return HALF1;
            2'h2:    return HALF2;
            default: return HALF3;
        endcase
    endfunction : half_cycles

    // position bits actually clocked, kept between one and the data width
    function automatic logic [5:0] eff_bits(input logic [5:0] cnt);
        if (cnt == 6'h00) begin
            return 6'h01;
        end
        if (32'(cnt) > DATA_W) begin
            return 6'(DATA_W);
        end
        return cnt;
    endfunction : eff_bits

    // gray to binary, top bit kept, lower bits chained through xor
    function automatic logic [31:0] gray_to_bin(input logic [31:0] g);
        logic [31:0] b;
        b = g;
        for (int i = MAX_BITS - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    // total bits in one frame: position, optional zero bit, optional parity
    function automatic logic [5:0] frame_bits(input ctrl_t c);
        return 6'(eff_bits(c.data_bit_count) + 6'(c.extra_zero_bit) + 6'(c.bit_check_enable));
    endfunction : frame_bits

    // controller operation only with function 01 and listening off
    assign std_mode = (cur.fn_sel == FN_SSI) && !cur.ctrl.listen_sel;
    assign bus_req  = wb_cyc && wb_stb && !cur.ack;
    assign data_bit = cur.sync[1];

    // outputs straight from the state flip-flops
    assign wb_dat_r    = cur.dat_r;
    assign wb_ack      = cur.ack;
    assign ssi_clk_out = cur.sclk;
    assign ssi_clk_oe  = cur.sclk_oe;
    assign irq         = cur.irq;

    // next state
    always_comb begin
        logic        start;
        logic [5:0]  nb;
        logic [31:0] raw;
        logic [31:0] ctrl_w;
        start  = 1'b0;
        ctrl_w = merge(32'(cur.ctrl), wb_dat_w, wb_sel); // byte merged control word
        nb    = eff_bits(cur.ctrl.data_bit_count);
        raw   = cur.shift;
        next  = cur;

        // data pin passes two flip-flops before use
        next.sync = {cur.sync[0], ssi_data_in};
        next.ack  = 1'b0;

        // register access, one wait-free answer per request
        if (bus_req) begin
            next.ack   = 1'b1;
            next.dat_r = 32'h0000_0000;
            case (wb_adr[7:2])
                IDX_CTRL: begin
                    next.dat_r = 32'(cur.ctrl);
                    if (wb_we) begin
                        next.ctrl = ctrl_t'(ctrl_w[$bits(ctrl_t)-1:0]);
                    end
                end
                IDX_DATA: begin
                    next.dat_r = cur.position;
                    if (wb_we) begin
                        start = 1'b1;
                    end
                end
                IDX_STATUS: begin
                    next.dat_r[STAT_BUSY]     = cur.busy;
                    next.dat_r[STAT_DONE]     = cur.done;
                    next.dat_r[STAT_PAR_ERR]  = cur.par_err;
                    next.dat_r[STAT_READ_ERR] = 1'b0;
                    if (wb_we && wb_sel[0]) begin
                        if (wb_dat_w[STAT_DONE]) begin
                            next.done = 1'b0;
                        end
                        if (wb_dat_w[STAT_PAR_ERR]) begin
                            next.par_err = 1'b0;
                        end
                    end
                end
                IDX_GLOBAL: begin
                    next.dat_r[1:0] = cur.fn_sel;
                    if (wb_we) begin
                        if (wb_sel[0]) begin
                            next.fn_sel = wb_dat_w[1:0];
                        end
                        if (wb_sel[1] && wb_dat_w[GLOB_MULTI]) begin
                            start = 1'b1;
                        end
                    end
                end
                default: begin
                    next.dat_r = 32'h0000_0000; // unmapped reads zero, writes dropped
                end
            endcase
        end

        // accept a start only in controller operation and when not busy
        if (start && std_mode && !cur.busy) begin
            next.busy       = 1'b1;
            next.start_pend = 1'b1;
        end

        // clock pin is driven only in controller operation
        next.sclk_oe = std_mode;

        // burst sequencer
        case (cur.phase)
            PH_IDLE: begin
                next.sclk = 1'b1;
                if (cur.start_pend && !std_mode) begin
                    next.start_pend = 1'b0;
                    next.busy       = 1'b0;
                end else if (cur.start_pend) begin
                    // first falling edge latches the encoder position
                    next.start_pend = 1'b0;
                    next.sclk       = 1'b0;
                    next.timer      = half_cycles(cur.ctrl.clock_rate_sel) - 16'h0001;
                    next.bits       = 6'h00;
                    next.shift      = 32'h0000_0000;
                    next.par_bit    = 1'b0;
                    next.phase      = PH_LO;
                end
            end
            PH_LO: begin
                if (!std_mode) begin
                    next.sclk  = 1'b1;
                    next.busy  = 1'b0;
                    next.phase = PH_IDLE;
                end else if (cur.timer != 16'h0000) begin
                    next.timer = cur.timer - 16'h0001;
                end else begin
                    // rising edge, encoder shifts out its next bit
                    next.sclk  = 1'b1;
                    next.timer = half_cycles(cur.ctrl.clock_rate_sel) - 16'h0001;
                    next.phase = PH_HI;
                end
            end
            PH_HI: begin
                if (!std_mode) begin
                    next.busy  = 1'b0;
                    next.phase = PH_IDLE;
                end else if (cur.timer != 16'h0000) begin
                    next.timer = cur.timer - 16'h0001;
                end else if (cur.bits == frame_bits(cur.ctrl)) begin
                    next.phase = PH_PROC; // clock rests high after the last bit
                end else begin
                    // falling edge, the bit set up at the rising edge is taken
                    next.sclk  = 1'b0;
                    next.timer = half_cycles(cur.ctrl.clock_rate_sel) - 16'h0001;
                    next.bits  = cur.bits + 6'h01;
                    next.phase = PH_LO;
                    if (cur.bits < nb) begin
                        next.shift = {cur.shift[30:0], data_bit};
                    end else if (cur.ctrl.extra_zero_bit && cur.bits == nb) begin
                        next.shift = cur.shift;
                    end else begin
                        next.par_bit = data_bit;
                    end
                end
            end
            PH_PROC: begin
                // decode and check, then report completion
                next.position = cur.ctrl.gray_sel ? gray_to_bin(raw) : raw;
                if (cur.ctrl.bit_check_enable && ((^raw ^ cur.par_bit) != cur.ctrl.odd_even_sel)) begin
                    next.par_err = 1'b1;
                end
                next.busy  = 1'b0;
                next.done  = 1'b1;
                next.timer = RECOVERY_CYC - 16'h0001;
                next.phase = PH_REC;
            end
            PH_REC: begin
                // wait out the least recovery time, then for data to return high
                if (cur.timer != 16'h0000) begin
                    next.timer = cur.timer - 16'h0001;
                end else if (data_bit) begin
                    next.phase = PH_IDLE;
                end
            end
            default: begin
                next.phase = PH_IDLE;
                next.sclk  = 1'b1;
                next.busy  = 1'b0;
            end
        endcase

        // interrupt follows the pending completion when enabled
        next.irq = next.done && next.ctrl.irq_enable;
    end

    // state register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next;
        end
    end

endmodule : ssi_encoder_reader

// [pkg/ssi_reader_pkg.sv]
// register map, field layout, timing constants and state types of the serial encoder reader
// How it works
// - Serial clock and encoder data both rest high while no transfer runs.
// - A position read sends a train of clock pulses to the encoder.
// - Each later rising edge brings the next lower bit; bits are collected in order.
// - Optional zero bit, then optional parity bit, follow the position bits.
// - After a full frame no new burst starts before the recovery time ends and data is high again; an aborted burst skips this.
// - Channel is a serial controller only with function select 01 and listen off.
// - In controller operation the clock pin is driven and data is sampled.
// - Bit count, coding, zero bit, parity sense, parity check, clock rate are settable.
// - A write to the data register starts one clock burst.
// - Parity is checked when enabled, Gray is turned to binary when selected.
// - On completion busy clears and the position is readable in the data register.
// - With the interrupt enabled, completion raises the interrupt.
// - The read error status bit always reads zero in controller operation.
// - Busy reads one for the whole transfer.
// - A multiple-channel read command also starts a transfer.
// - A pending completion shows as a status bit and is cleared by writing one.
package ssi_reader_pkg;

    // core clock
    localparam int CLK_HZ = 100_000_000;
    localparam int MAX_BITS = 32;

    // register word indices, byte address is four times the index
    localparam logic [5:0] IDX_CTRL   = 6'h00;
    localparam logic [5:0] IDX_DATA   = 6'h01;
    localparam logic [5:0] IDX_STATUS = 6'h02;
    localparam logic [5:0] IDX_GLOBAL = 6'h03;

    // status and global field positions
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DONE     = 1;
    localparam int STAT_PAR_ERR  = 2;
    localparam int STAT_READ_ERR = 3;
    localparam int GLOB_MULTI    = 8;

    // function select value for serial controller operation
    localparam logic [1:0] FN_SSI = 2'h1;
    localparam logic [1:0] FN_RESET = 2'h0;

    // serial clock rates selected by clock_rate_sel, in kHz
    localparam int RATE0_KHZ = 1000;
    localparam int RATE1_KHZ = 500;
    localparam int RATE2_KHZ = 250;
    localparam int RATE3_KHZ = 125;
    localparam logic [15:0] HALF0 = 16'(CLK_HZ / (2 * RATE0_KHZ * 1000));
    localparam logic [15:0] HALF1 = 16'(CLK_HZ / (2 * RATE1_KHZ * 1000));
    localparam logic [15:0] HALF2 = 16'(CLK_HZ / (2 * RATE2_KHZ * 1000));
    localparam logic [15:0] HALF3 = 16'(CLK_HZ / (2 * RATE3_KHZ * 1000));

    // least encoder recovery time, rounded up to whole cycles
    localparam int RECOVERY_MIN_NS = 10_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam logic [15:0] RECOVERY_CYC = 16'((RECOVERY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // per channel settings
    typedef struct packed {
        logic       listen_sel;
        logic       irq_enable;
        logic [1:0] clock_rate_sel;
        logic       bit_check_enable;
        logic       odd_even_sel;
        logic       extra_zero_bit;
        logic       gray_sel;
        logic [5:0] data_bit_count;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{data_bit_count: 6'h0D, default: '0};

    typedef enum logic [2:0] {
        PH_IDLE = 3'h0,
        PH_LO   = 3'h1,
        PH_HI   = 3'h3,
        PH_PROC = 3'h2,
        PH_REC  = 3'h6
    } phase_t;

    // whole state of the reader
    typedef struct packed {
        phase_t      phase;
        ctrl_t       ctrl;
        logic [1:0]  fn_sel;
        logic        start_pend;
        logic        busy;
        logic        done;
        logic        par_err;
        logic [15:0] timer;
        logic [5:0]  bits;
        logic [31:0] shift;
        logic        par_bit;
        logic [31:0] position;
        logic [1:0]  sync;
        logic        sclk;
        logic        sclk_oe;
        logic        ack;
        logic [31:0] dat_r;
        logic        irq;
    } state_t;

    localparam state_t STATE_RESET = '{phase: PH_IDLE, ctrl: CTRL_RESET, fn_sel: FN_RESET,
                                       sync: 2'h3, sclk: 1'b1, default: '0};

endpackage : ssi_reader_pkg

// [verif/ssi_encoder_model.sv]
// behavioural absolute encoder on the serial clock and data lines
`timescale 1ns/1ps
module ssi_encoder_model (
    // encoder link
    input  wire logic        sclk,
    output logic             sdata,
    // frame contents, msb sent first
    input  wire logic [31:0] frame,
    input  wire logic [5:0]  nbits
);
    logic [31:0] held;
    int          sent;
    logic        active;
    initial begin
        sdata  = 1'b1;
        active = 1'b0;
        sent   = 0;
        held   = 32'h0;
    end
    // first fall of a burst latches the frame, ignored while recovering
    always @(negedge sclk) begin
        if (!active && sdata) begin
            held   <= frame;
            active <= 1'b1;
            sent   <= 0;
        end
    end
    // each rise shifts out the next lower bit, then recovery low
    always @(posedge sclk) begin
        if (active) begin
            if (sent < int'(nbits)) begin
                sdata <= held[int'(nbits) - 1 - sent];
                sent  <= sent + 1;
            end else begin
                sdata  <= 1'b0;
                active <= 1'b0;
                sdata  <= #15000 1'b1;
            end
        end
    end
endmodule : ssi_encoder_model

// [verif/ssi_reader_properties.sv]
// port level assertions for the serial encoder reader
`timescale 1ns/1ps
module ssi_reader_properties
    import ssi_reader_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // system
    input wire logic        clk,
    input wire logic        rstn,
    // wishbone slave
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_we,
    input wire logic [7:0]  wb_adr,
    input wire logic [3:0]  wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic        wb_ack,
    // encoder link
    input wire logic        ssi_clk_out,
    input wire logic        ssi_clk_oe,
    input wire logic        ssi_data_in,
    // completion event
    input wire logic        irq
);
    logic [15:0] lo_cnt;
    logic [15:0] hi_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // length of the running low and high serial clock phase, high count saturates
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lo_cnt <= 16'h0000;
            hi_cnt <= 16'hFFFF;
        end else begin
            lo_cnt <= ssi_clk_out ? 16'h0000 : lo_cnt + 16'h0001;
            hi_cnt <= !ssi_clk_out ? 16'h0000 : ((hi_cnt == 16'hFFFF) ? hi_cnt : hi_cnt + 16'h0001);
        end
    end
    a_idle_clk_high: assert property (!ssi_clk_oe |-> ssi_clk_out)
        else $error("serial clock low while pin not driven");
    a_low_needs_oe: assert property (!ssi_clk_out |-> ssi_clk_oe)
        else $error("clock pulse without output enable");
    a_low_phase_min: assert property ($rose(ssi_clk_out) |-> lo_cnt >= 16'h0032)
        else $error("low clock phase shorter than fastest rate");
    a_burst_gap: assert property ($fell(ssi_clk_out) |-> (hi_cnt <= 16'h0190 || hi_cnt >= 16'h03E8))
        else $error("new burst inside encoder recovery");
    a_read_err_zero: assert property (wb_ack && !wb_we && wb_adr[7:2] == IDX_STATUS
        |-> !wb_dat_r[STAT_READ_ERR])
        else $error("read error bit set in controller mode");
    a_unmapped_zero: assert property (wb_ack && !wb_we && wb_adr[7:2] > IDX_GLOBAL |-> wb_dat_r == 32'h0)
        else $error("unmapped read not zero");
    a_ack_latency: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack not one cycle after request");
    a_ack_pulse: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    a_ack_needs_req: assert property (!(wb_cyc && wb_stb) |=> !wb_ack)
        else $error("ack without request");
    a_irq_at_rest: assert property ($rose(irq) |-> ssi_clk_out && $stable(ssi_clk_out) [*2])
        else $error("interrupt raised during a burst");
endmodule : ssi_reader_properties

bind ssi_encoder_reader ssi_reader_properties #(.DATA_W(DATA_W)) chk_u (
    .clk(clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .ssi_clk_out(ssi_clk_out), .ssi_clk_oe(ssi_clk_oe), .ssi_data_in(ssi_data_in), .irq(irq));

// [verif/test_ssi_encoder_reader.sv]
// register level testbench of the serial encoder reader with an encoder model
`timescale 1ns/1ps
module test_ssi_encoder_reader;
    import ssi_reader_pkg::*;
    logic        clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, ssi_clk_out, ssi_clk_oe, link_data, irq;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, frm, d;
    logic [5:0]  nb;
    wire  logic  link_clk = ssi_clk_oe ? ssi_clk_out : 1'b1;
    int          err_total = 0;
    int          checked = 0;
    // per case: control word, frame on the wire, frame bits, expected data and status
    localparam logic [31:0] CFG [4] = '{32'h0000000D, 32'h000016C8, 32'h00000B04, 32'h00000C00};
    localparam logic [31:0] FRM [4] = '{32'h00001A5B, 32'h000002D0, 32'h0000000F, 32'h00000001};
    localparam logic [5:0]  NB  [4] = '{6'h0D, 6'h0A, 6'h05, 6'h01};
    localparam logic [31:0] EXP [4] = '{32'h00001A5B, 32'h000000D8, 32'h00000007, 32'h00000001};
    localparam logic [31:0] EST [4] = '{32'h00000002, 32'h00000002, 32'h00000006, 32'h00000002};
    ssi_encoder_reader dut_u (.clk(clk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .ssi_clk_out(ssi_clk_out), .ssi_clk_oe(ssi_clk_oe), .ssi_data_in(link_data), .irq(irq));
    ssi_encoder_model enc_u (.sclk(link_clk), .sdata(link_data), .frame(frm), .nbits(nb));
    // one classic wishbone cycle, held until ack
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dw,
                            output logic [31:0] dr);
        @(posedge clk);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_dat_w <= dw;
        do @(posedge clk); while (wb_ack !== 1'b1);
        dr = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb_cycle
    // compare one value and count it
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // read a register and compare it
    task automatic rd_cmp(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb_cycle(1'b0, adr, 32'h0, r);
        cmp(r, exp);
    endtask : rd_cmp
    // counts, verdict and end of run
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    // core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watchdog
    initial begin
        #400_000;
        err_total++;
        print_verdict();
    end
    // main sequence
    initial begin
        rstn = 1'b0; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0;
        wb_adr = 8'h00; wb_sel = 4'hF; wb_dat_w = 32'h0; frm = 32'h0; nb = 6'h01;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_cmp(8'h00, 32'h0000000D);
        rd_cmp(8'h0C, 32'h00000000);
        wb_cycle(1'b1, 8'h10, 32'hFFFFFFFF, d);
        rd_cmp(8'h10, 32'h00000000);
        wb_cycle(1'b1, 8'h04, 32'h0, d);
        rd_cmp(8'h08, 32'h00000000);
        wb_cycle(1'b1, 8'h0C, 32'h00000001, d);
        @(posedge clk);
        cmp({30'h0, ssi_clk_oe, ssi_clk_out}, 32'h00000003);
        for (int i = 0; i < 4; i++) begin
            wb_cycle(1'b1, 8'h00, CFG[i], d);
            rd_cmp(8'h00, CFG[i]);
            frm <= FRM[i];
            nb  <= NB[i];
            if (i == 1) wb_cycle(1'b1, 8'h0C, 32'h00000101, d);
            else wb_cycle(1'b1, 8'h04, 32'h0, d);
            rd_cmp(8'h08, 32'h00000001);
            do wb_cycle(1'b0, 8'h08, 32'h0, d); while (d[STAT_BUSY] !== 1'b0);
            cmp(d, EST[i]);
            rd_cmp(8'h04, EXP[i]);
            cmp({31'h0, irq}, {31'h0, CFG[i][12]});
            rd_cmp(8'h08, EST[i]);
            wb_cycle(1'b1, 8'h08, 32'h00000006, d);
            rd_cmp(8'h08, 32'h00000000);
            cmp({31'h0, irq}, 32'h0);
        end
        wb_cycle(1'b1, 8'h00, 32'h0000200D, d);
        @(posedge clk);
        cmp({31'h0, ssi_clk_oe}, 32'h0);
        wb_cycle(1'b1, 8'h04, 32'h0, d);
        rd_cmp(8'h08, 32'h00000000);
        print_verdict();
    end
endmodule : test_ssi_encoder_reader
